// *** hw/lsr_pkg.sv ***
// Package with register layout, access encodings and sizes for the local SRAM block
package lsr_pkg;
    localparam int NUM_MODULES = 2;
    localparam int WORD_COUNT = 512;
    localparam int WORD_ADDR_W = 9;
    localparam int BASE_HI = 31;
    localparam int BASE_LO = 11;
    localparam int WP_BIT = 8;
    localparam int DI_BIT = 7;
    localparam int MASK_HI = 5;
    localparam int MASK_LO = 1;
    localparam int VALID_BIT = 0;
    localparam logic [31:0] WRITABLE_BITS = 32'hFFFF_F9BF;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Space indexes into the five-bit mask field
    localparam int SPACE_UD = 0;
    localparam int SPACE_UC = 1;
    localparam int SPACE_SD = 2;
    localparam int SPACE_SC = 3;
    localparam int SPACE_CPU = 4;

    typedef enum logic [2:0] {
        LSR_SP_USER_DATA = 3'h0,
        LSR_SP_USER_CODE = 3'h1,
        LSR_SP_SUPER_DATA = 3'h2,
        LSR_SP_SUPER_CODE = 3'h3,
        LSR_SP_CPU = 3'h4
    } lsr_space_e;

    typedef enum logic [1:0] {
        LSR_SRC_SRAM = 2'h0,
        LSR_SRC_CACHE = 2'h1,
        LSR_SRC_EXT = 2'h2
    } lsr_route_e;
endpackage

// *** hw/lsr_cfg_if.sv ***
// Interface carrying one module's decoded configuration to its memory
`timescale 1ns/10ps
interface lsr_cfg_if;
    logic valid;
    logic instr_bus;
    logic wr_protect;
    logic [4:0] space_mask_bits;
    logic [20:0] base;
    modport ctrl (output valid, output instr_bus, output wr_protect, output space_mask_bits,
        output base);
    modport mem (input valid, input instr_bus, input wr_protect, input space_mask_bits,
        input base);
endinterface

// *** hw/lsr_bank.sv ***
// One 2-Kbyte SRAM module: hit decode and 512 x 32 storage
`timescale 1ns/10ps
module lsr_bank (
    input wire logic clk,
    lsr_cfg_if.mem cfg,
    input wire logic req,
    input wire logic is_instr,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [2:0] space,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    output logic hit,
    output logic [31:0] rdata
);
    logic [31:0] mem_q [lsr_pkg::WORD_COUNT];
    logic [lsr_pkg::WORD_ADDR_W-1:0] idx;
    logic do_write;
    logic [31:0] rdata_d;

    assign idx = addr[lsr_pkg::BASE_LO-1:2];
    // valid, bus type, base and mask all qualify
    always_comb begin
        hit = req && cfg.valid && (cfg.instr_bus == is_instr)
            && (addr[lsr_pkg::BASE_HI:lsr_pkg::BASE_LO] == cfg.base)
            && !cfg.space_mask_bits[space];
        do_write = hit && wr && !cfg.wr_protect;
        rdata_d = mem_q[idx];
    end

    always_ff @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (do_write && be[b]) begin
                mem_q[idx][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
        rdata <= rdata_d;
    end
endmodule

// *** hw/lsr_top.sv ***
// Local SRAM pair with base decode, priority routing and config registers
// Contract
// - Each module covers 2 Kbytes based at register bits 31 to 11.
// - One access per clock is accepted back to back.
// - Bit 7 attaches module to data bus at 0, instruction bus at 1.
// - Instruction fetch hitting SRAM takes SRAM data, cache data discarded.
// - Data access hitting SRAM leaves cache contents and state untouched.
// - SRAM data is never allocated into the cache.
// - Debug module references count as data accesses.
// - DMA has no path to SRAM; core runs alongside DMA.
// - Priority is SRAM, then cache if cacheable, then external bus.
// - Core may only write the config register, never read it.
// - Debug module may read and write each config register.
// - Reserved bits 10..9 and 6 ignore writes and read zero.
// - Reset clears only the valid bit; other bits keep their value.
// - Write-protect bit 8 makes writes raise an access error.
// - Mask bits 5..1 make matching spaces bypass SRAM.
// - Valid bit 0 clear means module answers no access.
// - Each module is 512 x 32 with byte, word, longword access.
`timescale 1ns/10ps
module lsr_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CORE_REQ,
    input wire logic CORE_INSTR,
    input wire logic CORE_WR,
    input wire logic [31:0] CORE_ADDR,
    input wire logic [2:0] CORE_SPACE,
    input wire logic [3:0] CORE_BE,
    input wire logic [31:0] CORE_WDATA,
    input wire logic CORE_CACHEABLE,
    input wire logic DBG_REQ,
    input wire logic DBG_WR,
    input wire logic [31:0] DBG_ADDR,
    input wire logic [2:0] DBG_SPACE,
    input wire logic [3:0] DBG_BE,
    input wire logic [31:0] DBG_WDATA,
    input wire logic CORE_CFG_WR,
    input wire logic CORE_CFG_SEL,
    input wire logic [31:0] CORE_CFG_WDATA,
    input wire logic DBG_CFG_WR,
    input wire logic DBG_CFG_RD,
    input wire logic DBG_CFG_SEL,
    input wire logic [31:0] DBG_CFG_WDATA,
    input wire logic [31:0] CACHE_RDATA,
    output logic [31:0] DBG_CFG_RDATA,
    output logic RESP_VALID,
    output logic [31:0] RESP_RDATA,
    output logic RESP_FROM_SRAM,
    output logic ACCESS_ERROR,
    output logic CACHE_LOOKUP,
    output logic CACHE_ALLOC_INHIBIT,
    output logic EXT_REQ,
    output logic SRAM_BUSY
);
    // Config storage: valid bit is reset, the rest is deliberately not
    logic [31:0] cfg_q [lsr_pkg::NUM_MODULES];
    logic [31:0] cfg_d [lsr_pkg::NUM_MODULES];
    logic valid_q [lsr_pkg::NUM_MODULES];
    logic valid_d [lsr_pkg::NUM_MODULES];
    logic [31:0] dbg_rdata_d;
    logic [31:0] dbg_rdata_q;

    // Shared access port; debug wins when both request
    logic acc_req;
    logic acc_instr;
    logic acc_wr;
    logic [31:0] acc_addr;
    logic [2:0] acc_space;
    logic [3:0] acc_be;
    logic [31:0] acc_wdata;
    logic [lsr_pkg::NUM_MODULES-1:0] hit;
    logic [31:0] bank_rdata [lsr_pkg::NUM_MODULES];
    logic any_hit;
    logic [lsr_pkg::NUM_MODULES-1:0] wp_hit;

    // Response pipeline stage
    logic resp_valid_d;
    logic resp_valid_q;
    logic resp_sram_d;
    logic resp_sram_q;
    logic resp_err_d;
    logic resp_err_q;
    logic sel_d;
    logic sel_q;
    logic [31:0] resp_rdata;

    always_comb begin
        if (DBG_REQ) begin
            acc_req = 1'b1;
            acc_instr = 1'b0;
            acc_wr = DBG_WR;
            acc_addr = DBG_ADDR;
            acc_space = DBG_SPACE;
            acc_be = DBG_BE;
            acc_wdata = DBG_WDATA;
        end else begin
            acc_req = CORE_REQ;
            acc_instr = CORE_INSTR;
            acc_wr = CORE_WR;
            acc_addr = CORE_ADDR;
            acc_space = CORE_SPACE;
            acc_be = CORE_BE;
            acc_wdata = CORE_WDATA;
        end
    end

    // Config register write and debug read port
    always_comb begin
        dbg_rdata_d = dbg_rdata_q;
        for (int m = 0; m < lsr_pkg::NUM_MODULES; m++) begin
            cfg_d[m] = cfg_q[m];
            valid_d[m] = valid_q[m];
            // core writes only, no read path
            if (CORE_CFG_WR && (int'(CORE_CFG_SEL) == m) && !(DBG_CFG_WR)) begin
                cfg_d[m] = CORE_CFG_WDATA & lsr_pkg::WRITABLE_BITS;
                valid_d[m] = CORE_CFG_WDATA[lsr_pkg::VALID_BIT];
            end
            if (DBG_CFG_WR && (int'(DBG_CFG_SEL) == m)) begin
                cfg_d[m] = DBG_CFG_WDATA & lsr_pkg::WRITABLE_BITS;
                valid_d[m] = DBG_CFG_WDATA[lsr_pkg::VALID_BIT];
            end
        end
        if (DBG_CFG_RD) begin
            dbg_rdata_d = (cfg_q[DBG_CFG_SEL] & lsr_pkg::WRITABLE_BITS
                & ~(32'h0000_0001)) | {31'h0000_0000, valid_q[DBG_CFG_SEL]};
        end
    end

    // reset touches only the valid bits and the debug read data register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (int m = 0; m < lsr_pkg::NUM_MODULES; m++) begin
                valid_q[m] <= 1'b0;
            end
            dbg_rdata_q <= lsr_pkg::RESET_VALUE;
        end else begin
            for (int m = 0; m < lsr_pkg::NUM_MODULES; m++) begin
                valid_q[m] <= valid_d[m];
            end
            dbg_rdata_q <= dbg_rdata_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        for (int m = 0; m < lsr_pkg::NUM_MODULES; m++) begin
            cfg_q[m] <= cfg_d[m];
        end
    end

    assign DBG_CFG_RDATA = dbg_rdata_q;

    // One memory per config register; DMA has no port here
    genvar g;
    generate
        for (g = 0; g < lsr_pkg::NUM_MODULES; g++) begin : g_bank
            lsr_cfg_if cfg_bus ();
            // base field is bits 31 to 11
            assign cfg_bus.base = cfg_q[g][lsr_pkg::BASE_HI:lsr_pkg::BASE_LO];
            assign cfg_bus.instr_bus = cfg_q[g][lsr_pkg::DI_BIT];
            assign cfg_bus.wr_protect = cfg_q[g][lsr_pkg::WP_BIT];
            // masked spaces fall through to the normal path
            assign cfg_bus.space_mask_bits = cfg_q[g][lsr_pkg::MASK_HI:lsr_pkg::MASK_LO];
            // cleared valid bit disables every hit
            assign cfg_bus.valid = valid_q[g];
            lsr_bank u_bank (
                .clk(CLK_SYS),
                .cfg(cfg_bus),
                .req(acc_req),
                .is_instr(acc_instr),
                .wr(acc_wr),
                .addr(acc_addr),
                .space(acc_space),
                .be(acc_be),
                .wdata(acc_wdata),
                .hit(hit[g]),
                .rdata(bank_rdata[g])
            );
            assign wp_hit[g] = hit[g] && cfg_q[g][lsr_pkg::WP_BIT];
        end
    endgenerate

    // only core and debug reach the memories
    assign SRAM_BUSY = acc_req;

    // SRAM first, cache only if cacheable, else external
    always_comb begin
        any_hit = |hit;
        // no cache lookup or update on an SRAM hit
        CACHE_LOOKUP = acc_req && !any_hit && CORE_CACHEABLE && !DBG_REQ;
        EXT_REQ = acc_req && !any_hit && !(CORE_CACHEABLE && !DBG_REQ);
        CACHE_ALLOC_INHIBIT = any_hit;
        resp_valid_d = acc_req;
        resp_sram_d = any_hit;
        // write to protected module is an access error
        resp_err_d = acc_wr && (|wp_hit);
        sel_d = hit[1];
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            resp_valid_q <= 1'b0;
            resp_sram_q <= 1'b0;
            resp_err_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            resp_valid_q <= resp_valid_d;
            resp_sram_q <= resp_sram_d;
            resp_err_q <= resp_err_d;
            sel_q <= sel_d;
        end
    end

    always_comb begin
        resp_rdata = resp_sram_q ? bank_rdata[sel_q] : CACHE_RDATA;
    end

    assign RESP_VALID = resp_valid_q;
    assign RESP_FROM_SRAM = resp_sram_q;
    assign ACCESS_ERROR = resp_err_q;
    assign RESP_RDATA = resp_rdata;

    // Routing and priority of one access
    a_sram_excl: assert property (@(posedge CLK_SYS) disable iff (RST)
        (|hit) |-> !CACHE_LOOKUP && !EXT_REQ)
        else $error("SRAM hit also went to cache or bus");
    a_ext_miss: assert property (@(posedge CLK_SYS) disable iff (RST)
        EXT_REQ |-> acc_req && !(|hit))
        else $error("External access without a missed request");
    a_lookup_cch: assert property (@(posedge CLK_SYS) disable iff (RST)
        CACHE_LOOKUP |-> CORE_CACHEABLE && !DBG_REQ)
        else $error("Cache lookup for a non-cacheable access");
    a_miss_routed: assert property (@(posedge CLK_SYS) disable iff (RST)
        acc_req && !(|hit) |-> CACHE_LOOKUP != EXT_REQ)
        else $error("Missed access not sent to exactly one target");
    a_alloc_hit: assert property (@(posedge CLK_SYS) disable iff (RST)
        CACHE_ALLOC_INHIBIT |-> (|hit))
        else $error("Allocation inhibit without a hit");
    a_busy_req: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CORE_REQ || DBG_REQ) |-> SRAM_BUSY)
        else $error("Busy flag low during an access");
    a_dbg_data: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_REQ |-> !(|(hit & {cfg_q[1][7], cfg_q[0][7]})))
        else $error("Debug hit instruction module");
    a_dbg_route: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_REQ |-> !acc_instr && acc_addr == DBG_ADDR)
        else $error("Debug access not routed as data");

    // Per-module hit decode
    a_invalid_miss: assert property (@(posedge CLK_SYS) disable iff (RST)
        !valid_q[0] |-> !hit[0])
        else $error("Invalid module hit");
    a_invalid_miss1: assert property (@(posedge CLK_SYS) disable iff (RST)
        !valid_q[1] |-> !hit[1])
        else $error("Invalid second module hit");
    a_mask_miss: assert property (@(posedge CLK_SYS) disable iff (RST)
        cfg_q[0][lsr_pkg::MASK_LO + int'(acc_space)] && acc_space < 3'h5 |-> !hit[0])
        else $error("Masked space hit");
    a_mask_miss1: assert property (@(posedge CLK_SYS) disable iff (RST)
        cfg_q[1][lsr_pkg::MASK_LO + int'(acc_space)] && acc_space < 3'h5 |-> !hit[1])
        else $error("Masked space hit second module");
    a_base_match: assert property (@(posedge CLK_SYS) disable iff (RST)
        hit[1] |-> acc_addr[31:11] == cfg_q[1][31:11])
        else $error("Hit outside base region");
    a_base_match0: assert property (@(posedge CLK_SYS) disable iff (RST)
        hit[0] |-> acc_addr[lsr_pkg::BASE_HI:lsr_pkg::BASE_LO]
            == cfg_q[0][lsr_pkg::BASE_HI:lsr_pkg::BASE_LO])
        else $error("Hit outside base region of first module");
    a_bus_match0: assert property (@(posedge CLK_SYS) disable iff (RST)
        hit[0] |-> acc_instr == cfg_q[0][lsr_pkg::DI_BIT])
        else $error("First module hit on the wrong bus");
    a_bus_match1: assert property (@(posedge CLK_SYS) disable iff (RST)
        hit[1] |-> acc_instr == cfg_q[1][lsr_pkg::DI_BIT])
        else $error("Second module hit on the wrong bus");
    a_quiet_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
        !acc_req |-> !(|hit) && !CACHE_LOOKUP && !EXT_REQ)
        else $error("Activity without a request");

    // Response timing and error reporting
    a_resp_next: assert property (@(posedge CLK_SYS) disable iff (RST)
        acc_req |=> RESP_VALID)
        else $error("Access not answered next cycle");
    a_resp_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
        !acc_req |=> !RESP_VALID)
        else $error("Response without a request");
    // Inhibit is combinational, so it is checked in the hit cycle, not the reply
    a_resp_src: assert property (@(posedge CLK_SYS) disable iff (RST)
        (|hit) |-> CACHE_ALLOC_INHIBIT ##1 RESP_FROM_SRAM)
        else $error("SRAM hit not sourced from SRAM");
    a_wp_error: assert property (@(posedge CLK_SYS) disable iff (RST)
        (acc_wr && (|wp_hit)) |=> ACCESS_ERROR)
        else $error("Protected write without error");
    a_no_err_rd: assert property (@(posedge CLK_SYS) disable iff (RST)
        !acc_wr |=> !ACCESS_ERROR)
        else $error("Error on a read");
    a_err_needs_wp: assert property (@(posedge CLK_SYS) disable iff (RST)
        ACCESS_ERROR |-> $past(acc_wr && (|wp_hit)))
        else $error("Error without a protected write");
    a_invalid_err: assert property (@(posedge CLK_SYS) disable iff (RST)
        !valid_q[0] && !valid_q[1] |=> !RESP_FROM_SRAM && !ACCESS_ERROR)
        else $error("Disabled modules answered an access");

    // Config register behaviour
    a_rsv_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
        $past(DBG_CFG_RD) |-> (DBG_CFG_RDATA & 32'h0000_0640) == 32'h0000_0000)
        else $error("Reserved bits read nonzero");
    a_rsv_store: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_CFG_WR && !DBG_CFG_SEL |=> (cfg_q[0] & 32'h0000_0640) == 32'h0000_0000)
        else $error("Reserved bits stored by debug write");
    a_rsv_store1: assert property (@(posedge CLK_SYS) disable iff (RST)
        CORE_CFG_WR && CORE_CFG_SEL && !DBG_CFG_WR
            |=> (cfg_q[1] & 32'h0000_0640) == 32'h0000_0000)
        else $error("Reserved bits stored by core write");
    a_dbg_rd_valid: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_CFG_RD && !DBG_CFG_SEL |=> DBG_CFG_RDATA[0] == $past(valid_q[0]))
        else $error("Debug read shows wrong valid bit");
    a_dbg_rd_base: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_CFG_RD && !DBG_CFG_SEL |=> DBG_CFG_RDATA[lsr_pkg::BASE_HI:lsr_pkg::BASE_LO]
            == $past(cfg_q[0][lsr_pkg::BASE_HI:lsr_pkg::BASE_LO]))
        else $error("Debug read shows wrong base");
    a_dbg_wr_cfg: assert property (@(posedge CLK_SYS) disable iff (RST)
        DBG_CFG_WR && !DBG_CFG_SEL |=> valid_q[0] == $past(DBG_CFG_WDATA[0]))
        else $error("Debug write did not set valid bit");
    a_core_wr_cfg: assert property (@(posedge CLK_SYS) disable iff (RST)
        CORE_CFG_WR && !CORE_CFG_SEL && !DBG_CFG_WR |=> valid_q[0] == $past(CORE_CFG_WDATA[0]))
        else $error("Core write did not set valid bit");
    a_cfg_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
        !CORE_CFG_WR && !DBG_CFG_WR |=> $stable(valid_q[0]) && $stable(valid_q[1]))
        else $error("Valid bit changed without a write");

    // Main scenarios
    c_sram_rd: cover property (@(posedge CLK_SYS) disable iff (RST)
        (|hit) && !acc_wr);
    c_sram_b2b: cover property (@(posedge CLK_SYS) disable iff (RST)
        (|hit) ##1 (|hit));
    c_wp_err: cover property (@(posedge CLK_SYS) disable iff (RST) ACCESS_ERROR);
    c_ext: cover property (@(posedge CLK_SYS) disable iff (RST) EXT_REQ);
    c_instr_hit: cover property (@(posedge CLK_SYS) disable iff (RST)
        (|hit) && acc_instr);
endmodule

// *** sim/lsr_cache_model.sv ***
// Behavioural cache data port facing the local SRAM block
`timescale 1ns/10ps
module lsr_cache_model #(
    parameter logic [31:0] KEY = 32'h5A5A_0000
) (
    input wire logic clk,
    input wire logic lookup,
    input wire logic dbg_req,
    input wire logic [31:0] core_addr,
    input wire logic [31:0] dbg_addr,
    output logic [31:0] rdata
);
    initial rdata = 32'h0000_0000;
    // Idle cycles toggle the bus so stale data never looks like a hit
    always @(posedge clk) begin
        if (lookup) begin
            rdata <= (dbg_req ? dbg_addr : core_addr) ^ KEY;
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// *** sim/tb_lsr_top.sv ***
// Self-checking bench for the local SRAM pair and its config registers
`timescale 1ns/10ps
module tb_lsr_top;
    localparam logic [31:0] KEY = 32'h5A5A_0000;
    logic CLK_SYS, RST, CORE_REQ, CORE_INSTR, CORE_WR, CORE_CACHEABLE, DBG_REQ, DBG_WR;
    logic CORE_CFG_WR, CORE_CFG_SEL, DBG_CFG_WR, DBG_CFG_RD, DBG_CFG_SEL;
    logic [31:0] CORE_ADDR, CORE_WDATA, DBG_ADDR, DBG_WDATA, CORE_CFG_WDATA, DBG_CFG_WDATA;
    logic [31:0] CACHE_RDATA, DBG_CFG_RDATA, RESP_RDATA;
    logic [2:0] CORE_SPACE, DBG_SPACE;
    logic [3:0] CORE_BE, DBG_BE;
    logic RESP_VALID, RESP_FROM_SRAM, ACCESS_ERROR, CACHE_LOOKUP, CACHE_ALLOC_INHIBIT, EXT_REQ;
    logic SRAM_BUSY;
    int num_errors = 0;
    int tests_run = 0;

    lsr_top i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .CORE_REQ(CORE_REQ), .CORE_INSTR(CORE_INSTR),
        .CORE_WR(CORE_WR), .CORE_ADDR(CORE_ADDR), .CORE_SPACE(CORE_SPACE), .CORE_BE(CORE_BE),
        .CORE_WDATA(CORE_WDATA), .CORE_CACHEABLE(CORE_CACHEABLE), .DBG_REQ(DBG_REQ),
        .DBG_WR(DBG_WR), .DBG_ADDR(DBG_ADDR), .DBG_SPACE(DBG_SPACE), .DBG_BE(DBG_BE),
        .DBG_WDATA(DBG_WDATA), .CORE_CFG_WR(CORE_CFG_WR), .CORE_CFG_SEL(CORE_CFG_SEL),
        .CORE_CFG_WDATA(CORE_CFG_WDATA), .DBG_CFG_WR(DBG_CFG_WR), .DBG_CFG_RD(DBG_CFG_RD),
        .DBG_CFG_SEL(DBG_CFG_SEL), .DBG_CFG_WDATA(DBG_CFG_WDATA), .CACHE_RDATA(CACHE_RDATA),
        .DBG_CFG_RDATA(DBG_CFG_RDATA), .RESP_VALID(RESP_VALID), .RESP_RDATA(RESP_RDATA),
        .RESP_FROM_SRAM(RESP_FROM_SRAM), .ACCESS_ERROR(ACCESS_ERROR),
        .CACHE_LOOKUP(CACHE_LOOKUP), .CACHE_ALLOC_INHIBIT(CACHE_ALLOC_INHIBIT),
        .EXT_REQ(EXT_REQ), .SRAM_BUSY(SRAM_BUSY));

    lsr_cache_model #(.KEY(KEY)) i_cache (.clk(CLK_SYS), .lookup(CACHE_LOOKUP),
        .dbg_req(DBG_REQ), .core_addr(CORE_ADDR), .dbg_addr(DBG_ADDR), .rdata(CACHE_RDATA));

    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset(input int n);
        RST = 1'b1;
        repeat (n) @(posedge CLK_SYS);
        #1 RST = 1'b0;
    endtask

    task automatic ccfg(input logic sel, input logic [31:0] d);
        CORE_CFG_SEL = sel;
        CORE_CFG_WDATA = d;
        CORE_CFG_WR = 1'b1;
        @(posedge CLK_SYS);
        #1 CORE_CFG_WR = 1'b0;
    endtask

    task automatic dcfg(input logic sel, input logic [31:0] d);
        DBG_CFG_SEL = sel;
        DBG_CFG_WDATA = d;
        DBG_CFG_WR = 1'b1;
        @(posedge CLK_SYS);
        #1 DBG_CFG_WR = 1'b0;
    endtask

    task automatic drd(input logic sel, input logic [31:0] exp);
        DBG_CFG_SEL = sel;
        DBG_CFG_RD = 1'b1;
        @(posedge CLK_SYS);
        #1 DBG_CFG_RD = 1'b0;
        chk(DBG_CFG_RDATA, exp);
    endtask

    // Request stays up on exit so consecutive calls run back to back
    task automatic acc(input logic dbg, ins, wr, input logic [31:0] a, input logic [2:0] sp,
        input logic [3:0] be, input logic [31:0] wd, input logic cch, hit, err,
        input logic [31:0] ed);
        CORE_REQ = ~dbg;
        DBG_REQ = dbg;
        CORE_INSTR = ins;
        CORE_WR = wr;
        DBG_WR = wr;
        CORE_ADDR = a;
        DBG_ADDR = a;
        CORE_SPACE = sp;
        DBG_SPACE = sp;
        CORE_BE = be;
        DBG_BE = be;
        CORE_WDATA = wd;
        DBG_WDATA = wd;
        CORE_CACHEABLE = cch;
        // Debug misses never look in the cache; they go straight out
        #1 chk({CACHE_LOOKUP, EXT_REQ, CACHE_ALLOC_INHIBIT},
            hit ? 3'h1 : ((cch && !dbg) ? 3'h4 : 3'h2));
        chk(SRAM_BUSY, 1'b1);
        @(posedge CLK_SYS);
        #1 chk({RESP_VALID, RESP_FROM_SRAM, ACCESS_ERROR}, {1'b1, hit, err});
        if (!wr && (hit || (cch && !dbg))) chk(RESP_RDATA, hit ? ed : a ^ KEY);
    endtask

    task automatic idle();
        CORE_REQ = 1'b0;
        DBG_REQ = 1'b0;
        #1 chk(SRAM_BUSY, 1'b0);
        @(posedge CLK_SYS);
        #1 chk(RESP_VALID, 1'b0);
    endtask

    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {CORE_REQ, CORE_INSTR, CORE_WR, CORE_CACHEABLE, DBG_REQ, DBG_WR, CORE_CFG_WR,
            CORE_CFG_SEL, DBG_CFG_WR, DBG_CFG_RD, DBG_CFG_SEL, CORE_ADDR, CORE_WDATA, DBG_ADDR,
            DBG_WDATA, CORE_CFG_WDATA, DBG_CFG_WDATA, CORE_SPACE, DBG_SPACE, CORE_BE,
            DBG_BE} = '0;
        // Reset from time zero so no edge sees unknown valid bits
        do_reset(8);
        dcfg(1'b0, 32'hFFFF_FFFF);
        drd(1'b0, 32'hFFFF_F9BF);
        ccfg(1'b0, 32'h2000_0035);
        drd(1'b0, 32'h2000_0035);
        ccfg(1'b1, 32'h3000_0801);
        drd(1'b1, 32'h3000_0801);
        $display("test registers done");
        acc(0, 0, 1, 32'h2000_0000, 3'h2, 4'hF, 32'h1122_3344, 1, 1, 0, 0);
        acc(0, 0, 1, 32'h2000_07FC, 3'h2, 4'hF, 32'hCAFE_F00D, 1, 1, 0, 0);
        acc(0, 0, 1, 32'h2000_0000, 3'h2, 4'h2, 32'hAABB_CCDD, 1, 1, 0, 0);
        acc(0, 0, 0, 32'h2000_0000, 3'h0, 4'hF, 0, 1, 1, 0, 32'h1122_CC44);
        acc(0, 0, 0, 32'h2000_07FC, 3'h2, 4'hF, 0, 1, 1, 0, 32'hCAFE_F00D);
        acc(0, 0, 0, 32'h2000_0800, 3'h2, 4'hF, 0, 1, 0, 0, 0);
        acc(0, 0, 0, 32'h2000_0000, 3'h1, 4'hF, 0, 0, 0, 0, 0);
        acc(0, 0, 0, 32'h2000_0000, 3'h4, 4'hF, 0, 1, 0, 0, 0);
        acc(0, 1, 0, 32'h2000_0000, 3'h2, 4'hF, 0, 1, 0, 0, 0);
        idle();
        acc(1, 0, 0, 32'h2000_0000, 3'h2, 4'hF, 0, 1, 1, 0, 32'h1122_CC44);
        idle();
        $display("test data path done");
        acc(0, 0, 1, 32'h3000_0804, 3'h2, 4'hF, 32'h1357_9BDF, 1, 1, 0, 0);
        idle();
        ccfg(1'b1, 32'h3000_0881);
        acc(0, 1, 0, 32'h3000_0804, 3'h3, 4'hF, 0, 1, 1, 0, 32'h1357_9BDF);
        acc(0, 0, 0, 32'h3000_0804, 3'h2, 4'hF, 0, 1, 0, 0, 0);
        acc(1, 0, 0, 32'h3000_0804, 3'h2, 4'hF, 0, 1, 0, 0, 0);
        idle();
        $display("test instruction bus done");
        ccfg(1'b0, 32'h2000_0135);
        acc(0, 0, 1, 32'h2000_0000, 3'h2, 4'hF, 32'hDEAD_BEEF, 1, 1, 1, 0);
        acc(0, 0, 0, 32'h2000_0000, 3'h2, 4'hF, 0, 1, 1, 0, 32'h1122_CC44);
        idle();
        $display("test write protect done");
        do_reset(8);
        drd(1'b0, 32'h2000_0134);
        drd(1'b1, 32'h3000_0880);
        acc(0, 0, 0, 32'h2000_0000, 3'h2, 4'hF, 0, 1, 0, 0, 0);
        idle();
        $display("test reset done");
        give_verdict();
    end
endmodule
